// ### pkg/bmtsf_pkg.sv
// Constants, types and state layout of the bus monitor track spread formatter.
// Assumes one clock domain and a synchronous active-high reset.
// Overview of operation
// - Tracks staggered by 24/count bit periods
// - At most four tracks per bus
// - Each track frame opens with sync
// - Same fixed frame length on all tracks
// - Words leave most significant bit first
// - Optional CRC word ends every track frame
// - Track one carries high time word
// - Track two carries low time word
// - Track three carries microsecond time word
// - Track four starts with first data word
// - Words dealt round-robin across tracks
// - Without frame time, data follows sync
// - Randomized NRZ-L or bi-phase-level line code
// - Formatted words are 24 bits wide
// - Strip bus sync and parity bits
// - Bus bit four lands in bit nine
// - Faulty words labelled error A or B
// - Command, status, data labels per channel
// - Time, check, fill, overflow label codes
// - Bus label is bus number minus one
// - Passive monitor, A primary, B secondary
// - Word faults are errors, protocol faults not
// - Sync pattern is faf320
// - Frame between 128 and 512 words
// - Fill words carry aaaa information
// - Bit one is odd parity or label
// - Buffer captured words to avoid loss
package bmtsf_pkg;
  localparam logic [23:0] SYNC_WORD = 24'hfaf320;
  localparam logic [8:0] LAST_SLOT = 9'h0ff;
  localparam logic [8:0] TIME_SLOTS = 9'h003;
  localparam logic [1:0] TIME_WORDS = 2'h3;
  localparam logic [15:0] FILL_INFO = 16'haaaa;
  localparam logic [15:0] CRC_POLY = 16'h8005;
  localparam logic [15:0] CRC_INIT = 16'h0000;
  localparam logic [4:0] LAST_BIT = 5'h17;
  localparam logic [3:0][4:0] TRACK_OFS = {5'h06, 5'h08, 5'h0c, 5'h18};
  localparam logic [3:0] LAB_CMD_A = 4'hf;
  localparam logic [3:0] LAB_CMD_B = 4'hb;
  localparam logic [3:0] LAB_ERR_A = 4'hc;
  localparam logic [3:0] LAB_ERR_B = 4'h8;
  localparam logic [3:0] LAB_TIME_HI = 4'h7;
  localparam logic [3:0] LAB_CRC = 4'h2;
  localparam logic [3:0] LAB_FILL = 4'h1;
  localparam logic [3:0] LAB_OVF = 4'h0;
  localparam logic [1:0] KIND_ERR = 2'h3;
  localparam logic [4:0] FIFO_DEPTH = 5'h10;
  localparam logic [4:0] FIFO_ROOM2 = 5'h0e;
  localparam logic [5:0] ADDR_CTRL = 6'h00;
  localparam logic [5:0] ADDR_STAT = 6'h01;
  localparam logic [10:0] CTRL_RST = 11'h000;
  localparam int CTRL_FTE = 2;
  localparam int CTRL_CRCE = 3;
  localparam int CTRL_PAR = 4;
  localparam int CTRL_BIP = 5;
  localparam int CTRL_RUN = 6;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_RUN = 2'b10} bmtsf_st_e_t;

  // kind: 0 command, 1 status, 2 data
  typedef struct packed {
    logic [19:0] raw;
    logic [1:0] kind;
    logic chan_b;
    logic fault;
  } bmtsf_cap_t;

  typedef struct packed {
    logic [15:0] hi;
    logic [15:0] lo;
    logic [15:0] us;
  } bmtsf_time_t;

  typedef struct packed {
    logic [1:0] tk;
    logic fte;
    logic crce;
    logic par;
    logic bip;
    logic [3:0] bus;
  } bmtsf_cfg_t;

  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } bmtsf_axi_t;

  typedef struct packed {
    bmtsf_st_e_t st;
    logic [10:0] ctrl;
    bmtsf_cfg_t cfg;
    logic half;
    logic [4:0] bitc;
    logic [3:0][23:0] sh;
    logic [3:0][8:0] slot;
    logic [3:0][15:0] crc;
    logic [3:0][14:0] scr;
    logic [3:0] cb;
    logic [3:0] dout;
    logic bclk;
    logic [1:0] tcnt;
    logic [2:0][15:0] tsnap;
    logic [15:0][23:0] mem;
    logic [4:0] wp;
    logic [4:0] rp;
    logic ovf_pend;
    logic [15:0] frames;
    logic [7:0] ovfs;
    bmtsf_axi_t ax;
  } bmtsf_state_t;
endpackage

// ### hw/bmtsf_formatter.sv
// Bus monitor word formatter spreading one bus over up to four PCM tracks.
// Assumes capture words arrive decoded, one per cycle at most, and that the
// AXI4-Lite master and the tape inputs share ref_clk.
`timescale 1ns/1ns
module bmtsf_formatter (
  input wire logic ref_clk, // Bit engine and bus clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic clk_en, // Freezes all state except reset while low
  input wire logic cap_valid, // One captured bus word this cycle
  input wire bmtsf_pkg::bmtsf_cap_t cap, // Captured word and its flags
  input wire bmtsf_pkg::bmtsf_time_t frame_time, // Current time words
  input wire logic s_axi_awvalid, // AXI4-Lite write address
  output logic s_axi_awready, // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr, // AXI4-Lite write address
  input wire logic s_axi_wvalid, // AXI4-Lite write data
  output logic s_axi_wready, // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata, // AXI4-Lite write data
  input wire logic [3:0] s_axi_wstrb, // AXI4-Lite byte strobes
  output logic s_axi_bvalid, // AXI4-Lite write response
  input wire logic s_axi_bready, // AXI4-Lite write response
  output logic [1:0] s_axi_bresp, // AXI4-Lite write response
  input wire logic s_axi_arvalid, // AXI4-Lite read address
  output logic s_axi_arready, // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr, // AXI4-Lite read address
  output logic s_axi_rvalid, // AXI4-Lite read data
  input wire logic s_axi_rready, // AXI4-Lite read data
  output logic [31:0] s_axi_rdata, // AXI4-Lite read data
  output logic [1:0] s_axi_rresp, // AXI4-Lite read response
  output logic [3:0] track_data, // Line coded track streams
  output logic [3:0] track_active, // Tracks in use
  output logic bit_clk // Bit clock, high in first half bit
);
  localparam bmtsf_pkg::bmtsf_state_t S_RST = '{
    st: bmtsf_pkg::ST_IDLE,
    bitc: bmtsf_pkg::LAST_BIT,
    ctrl: bmtsf_pkg::CTRL_RST,
    default: '0
  };

  bmtsf_pkg::bmtsf_state_t s_q;
  bmtsf_pkg::bmtsf_state_t s_d;
  logic [3:0] ld;
  logic [3:0] fill;
  logic [3:0][23:0] wv;
  logic [3:0] cap_lab;
  logic [23:0] cap_fmt;
  logic [4:0] fcnt;
  logic [4:0] bn;
  logic b;
  logic y;
  logic aw_hs;
  logic w_hs;
  logic aw_got;
  logic w_got;
  logic [7:0] wa;
  logic [31:0] wd;
  logic [3:0] ws;

  // Builds a word: bit one, bus label, content label, information
  function automatic logic [23:0] fmt_word(input bmtsf_pkg::bmtsf_cfg_t c,
                                           input logic [3:0] lab,
                                           input logic [15:0] info);
    logic [22:0] r;
    r = {c.bus[2:0], lab, info};
    return {c.par ? ~^r : c.bus[3], r};
  endfunction

  // Frame check over information fields only, msb first
  function automatic logic [15:0] crc_word(input logic [15:0] c,
                                           input logic [15:0] d);
    logic [15:0] r;
    logic fb;
    r = c;
    for (int i = 15; i >= 0; i--) begin
      fb = r[15] ^ d[i];
      r = {r[14:0], 1'b0};
      if (fb) begin
        r = r ^ bmtsf_pkg::CRC_POLY;
      end
    end
    return r;
  endfunction

  assign s_axi_awready = !s_q.ax.aw_got && !s_q.ax.bvalid;
  assign s_axi_wready = !s_q.ax.w_got && !s_q.ax.bvalid;
  assign s_axi_arready = !s_q.ax.rvalid;
  assign s_axi_bvalid = s_q.ax.bvalid;
  assign s_axi_bresp = s_q.ax.bresp;
  assign s_axi_rvalid = s_q.ax.rvalid;
  assign s_axi_rdata = s_q.ax.rdata;
  assign s_axi_rresp = s_q.ax.rresp;
  assign track_data = s_q.dout;
  assign bit_clk = s_q.bclk;
  assign track_active = (s_q.st == bmtsf_pkg::ST_RUN) ?
                        (4'hf >> (2'h3 - s_q.cfg.tk)) : 4'h0;

  always_comb begin
    s_d = s_q;
    ld = 4'h0;
    fill = 4'h0;
    wv = '0;
    bn = s_q.bitc;
    b = 1'b0;
    y = 1'b0;
    fcnt = s_q.wp - s_q.rp;
    // Only decoded words are seen; nothing is ever driven onto the bus
    cap_lab = (cap.chan_b ? bmtsf_pkg::LAB_CMD_B : bmtsf_pkg::LAB_CMD_A) -
              {2'h0, cap.fault ? bmtsf_pkg::KIND_ERR : cap.kind};
    cap_fmt = fmt_word(s_q.cfg, cap_lab, cap.raw[16:1]);

    // Capture into the word buffer; an overflow leaves a marker word
    if (cap_valid && s_q.st == bmtsf_pkg::ST_RUN) begin
      if (s_q.ovf_pend) begin
        if (fcnt <= bmtsf_pkg::FIFO_ROOM2) begin
          s_d.mem[s_q.wp[3:0]] = fmt_word(s_q.cfg, bmtsf_pkg::LAB_OVF, 16'h0000);
          s_d.mem[s_q.wp[3:0] + 4'h1] = cap_fmt;
          s_d.wp = s_q.wp + 5'h02;
          s_d.ovf_pend = 1'b0;
        end else begin
          s_d.ovfs = s_q.ovfs + 8'h01;
        end
      end else if (fcnt == bmtsf_pkg::FIFO_DEPTH) begin
        s_d.ovf_pend = 1'b1;
        s_d.ovfs = s_q.ovfs + 8'h01;
      end else begin
        s_d.mem[s_q.wp[3:0]] = cap_fmt;
        s_d.wp = s_q.wp + 5'h01;
      end
    end

    case (s_q.st)
      bmtsf_pkg::ST_IDLE: begin
        // Every stream restarts at a frame start with the latched setup
        s_d = S_RST;
        s_d.ctrl = s_q.ctrl;
        s_d.frames = s_q.frames;
        s_d.ovfs = s_q.ovfs;
        s_d.ax = s_q.ax;
        s_d.cfg = '{tk: s_q.ctrl[1:0], fte: s_q.ctrl[bmtsf_pkg::CTRL_FTE],
                    crce: s_q.ctrl[bmtsf_pkg::CTRL_CRCE],
                    par: s_q.ctrl[bmtsf_pkg::CTRL_PAR],
                    bip: s_q.ctrl[bmtsf_pkg::CTRL_BIP],
                    bus: s_q.ctrl[10:7]};
        if (s_q.ctrl[bmtsf_pkg::CTRL_RUN]) begin
          s_d.st = bmtsf_pkg::ST_RUN;
        end
      end
      bmtsf_pkg::ST_RUN: begin
        if (!s_q.ctrl[bmtsf_pkg::CTRL_RUN]) begin
          s_d.st = bmtsf_pkg::ST_IDLE;
        end
        s_d.half = ~s_q.half;
        if (s_q.half) begin
          bn = (s_q.bitc == bmtsf_pkg::LAST_BIT) ? 5'h00 : s_q.bitc + 5'h01;
          s_d.bitc = bn;
          for (int t = 0; t < 4; t++) begin
            // Track t takes its word t offsets after track zero
            ld[t] = (2'(t) <= s_q.cfg.tk) &&
                    (bn == 5'(5'(t) * bmtsf_pkg::TRACK_OFS[s_q.cfg.tk]));
            if (ld[t]) begin
              if (s_q.slot[t] == 9'h000) begin
                wv[t] = bmtsf_pkg::SYNC_WORD;
                if (t == 0) begin
                  s_d.tcnt = 2'h0;
                  s_d.tsnap = {frame_time.hi, frame_time.lo, frame_time.us};
                  s_d.frames = s_q.frames + 16'h0001;
                end
              end else if (s_q.cfg.crce && s_q.slot[t] == bmtsf_pkg::LAST_SLOT) begin
                wv[t] = fmt_word(s_q.cfg, bmtsf_pkg::LAB_CRC, s_q.crc[t]);
                s_d.crc[t] = bmtsf_pkg::CRC_INIT;
              end else begin
                // One shared sequence dealt in load order deals the words
                // round-robin; time words lead it when enabled
                if (s_q.cfg.fte && s_q.tcnt != bmtsf_pkg::TIME_WORDS &&
                    s_q.slot[t] <= bmtsf_pkg::TIME_SLOTS) begin
                  wv[t] = fmt_word(s_q.cfg, bmtsf_pkg::LAB_TIME_HI - {2'h0, s_q.tcnt},
                                   s_q.tsnap[2'h2 - s_q.tcnt]);
                  s_d.tcnt = s_q.tcnt + 2'h1;
                end else if (fcnt != 5'h00) begin
                  wv[t] = s_q.mem[s_q.rp[3:0]];
                  s_d.rp = s_q.rp + 5'h01;
                end else begin
                  wv[t] = fmt_word(s_q.cfg, bmtsf_pkg::LAB_FILL, bmtsf_pkg::FILL_INFO);
                  fill[t] = 1'b1;
                end
                s_d.crc[t] = crc_word(s_q.crc[t], wv[t][15:0]);
              end
              s_d.slot[t] = (s_q.slot[t] == bmtsf_pkg::LAST_SLOT) ? 9'h000 :
                            s_q.slot[t] + 9'h001;
              s_d.sh[t] = wv[t];
            end else begin
              s_d.sh[t] = {s_q.sh[t][22:0], 1'b0};
            end
            // Self-synchronising randomizer, one per track
            b = s_d.sh[t][23];
            y = b ^ s_q.scr[t][13] ^ s_q.scr[t][14];
            s_d.scr[t] = {s_q.scr[t][13:0], y};
            s_d.cb[t] = s_q.cfg.bip ? b : y;
          end
        end
        for (int t = 0; t < 4; t++) begin
          // Bi-phase-level inverts the second half of each bit
          s_d.dout[t] = (2'(t) <= s_q.cfg.tk) &&
                        (s_q.cfg.bip ? s_d.cb[t] ^ s_d.half : s_d.cb[t]);
        end
        s_d.bclk = ~s_d.half;
      end
      default: begin
        s_d.st = bmtsf_pkg::ST_IDLE;
      end
    endcase

    // Register slave; setup changes only take effect on the next run
    aw_hs = s_axi_awvalid && s_axi_awready;
    w_hs = s_axi_wvalid && s_axi_wready;
    aw_got = s_q.ax.aw_got || aw_hs;
    w_got = s_q.ax.w_got || w_hs;
    wa = aw_hs ? s_axi_awaddr : s_q.ax.awaddr;
    wd = w_hs ? s_axi_wdata : s_q.ax.wdata;
    ws = w_hs ? s_axi_wstrb : s_q.ax.wstrb;
    s_d.ax.awaddr = wa;
    s_d.ax.wdata = wd;
    s_d.ax.wstrb = ws;
    if (s_q.ax.bvalid && s_axi_bready) begin
      s_d.ax.bvalid = 1'b0;
    end
    if (aw_got && w_got) begin
      s_d.ax.aw_got = 1'b0;
      s_d.ax.w_got = 1'b0;
      s_d.ax.bvalid = 1'b1;
      s_d.ax.bresp = bmtsf_pkg::RESP_OK;
      if (wa[7:2] == bmtsf_pkg::ADDR_CTRL) begin
        if (ws[0]) begin
          s_d.ctrl[7:0] = wd[7:0];
        end
        if (ws[1]) begin
          s_d.ctrl[10:8] = wd[10:8];
        end
      end else if (wa[7:2] != bmtsf_pkg::ADDR_STAT) begin
        s_d.ax.bresp = bmtsf_pkg::RESP_SLVERR;
      end
    end else begin
      s_d.ax.aw_got = aw_got;
      s_d.ax.w_got = w_got;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      s_d.ax.rvalid = 1'b1;
      s_d.ax.rresp = bmtsf_pkg::RESP_OK;
      case (s_axi_araddr[7:2])
        bmtsf_pkg::ADDR_CTRL: begin
          s_d.ax.rdata = {21'h000000, s_q.ctrl};
        end
        bmtsf_pkg::ADDR_STAT: begin
          s_d.ax.rdata = {3'h0, fcnt, s_q.ovfs, s_q.frames};
        end
        default: begin
          s_d.ax.rdata = 32'h00000000;
          s_d.ax.rresp = bmtsf_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_q.ax.rvalid && s_axi_rready) begin
      s_d.ax.rvalid = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q <= S_RST;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  default clocking dc_chk @(posedge ref_clk iff clk_en);
  endclocking
  default disable iff (rst);

  sequence s_t0_sync;
    ld[0] && s_q.slot[0] == 9'h000;
  endsequence

  sequence s_t0_time;
    ld[0] && s_q.slot[0] == 9'h001 && s_q.cfg.fte;
  endsequence

  chk_sync_word:
    assert property (s_t0_sync |=> s_q.sh[0] == bmtsf_pkg::SYNC_WORD)
      else $error("track frame does not open with sync");
  chk_track_stagger:
    assert property ((s_t0_sync and s_q.cfg.tk == 2'h3) |->
                     ##12 (ld[1] || s_q.st != bmtsf_pkg::ST_RUN))
      else $error("second track not six bits behind the first");
  chk_track_limit:
    assert property (((ld >> s_q.cfg.tk) >> 1) == 4'h0)
      else $error("word loaded on an unused track");
  chk_msb_first:
    assert property ((s_q.st == bmtsf_pkg::ST_RUN && s_q.half && !ld[0]) |=>
                     s_q.sh[0][23:1] == $past(s_q.sh[0][22:0]))
      else $error("track word not shifted msb first");
  chk_frame_len:
    assert property (s_q.slot[0] <= bmtsf_pkg::LAST_SLOT)
      else $error("frame slot beyond frame length");
  chk_time_high:
    assert property (s_t0_time |=> s_q.sh[0][19:16] == bmtsf_pkg::LAB_TIME_HI)
      else $error("first track lacks high time word");
  chk_fill_info:
    assert property (fill[0] |-> wv[0][15:0] == bmtsf_pkg::FILL_INFO &&
                     wv[0][19:16] == bmtsf_pkg::LAB_FILL)
      else $error("fill word malformed");
  chk_info_map:
    assert property (cap_valid |-> cap_fmt[15:0] == cap.raw[16:1])
      else $error("bus bits misplaced in information field");
  chk_err_label:
    assert property ((cap_valid && cap.fault) |-> cap_fmt[19:16] ==
                     (cap.chan_b ? bmtsf_pkg::LAB_ERR_B : bmtsf_pkg::LAB_ERR_A))
      else $error("faulty word has wrong error label");
  chk_odd_parity:
    assert property ((cap_valid && s_q.cfg.par) |-> ^cap_fmt)
      else $error("formatted word parity not odd");

  // Second slot of each track, used to check what follows sync
  sequence s_t1_time;
    ld[1] && s_q.slot[1] == 9'h001 && s_q.cfg.fte;
  endsequence

  sequence s_t2_time;
    ld[2] && s_q.slot[2] == 9'h001 && s_q.cfg.fte;
  endsequence

  sequence s_t3_first;
    ld[3] && s_q.slot[3] == 9'h001 && s_q.cfg.fte;
  endsequence

  chk_time_low:
    assert property (s_t1_time |=>
                     s_q.sh[1][19:16] == bmtsf_pkg::LAB_TIME_HI - 4'h1)
      else $error("second track lacks low time word");
  chk_time_micro:
    assert property (s_t2_time |=>
                     s_q.sh[2][19:16] == bmtsf_pkg::LAB_TIME_HI - 4'h2)
      else $error("third track lacks microsecond time word");
  chk_fourth_data:
    assert property (s_t3_first |=>
                     (s_q.sh[3][19:16] < 4'h5 || s_q.sh[3][19:16] > 4'h7))
      else $error("fourth track carries a time word");
  chk_no_time:
    assert property ((ld[0] && s_q.slot[0] == 9'h001 && !s_q.cfg.fte) |=>
                     s_q.sh[0][19:16] != bmtsf_pkg::LAB_TIME_HI)
      else $error("time word sent with frame time off");
  chk_crc_label:
    assert property ((ld[0] && s_q.cfg.crce &&
                      s_q.slot[0] == bmtsf_pkg::LAST_SLOT) |=>
                     s_q.sh[0][19:16] == bmtsf_pkg::LAB_CRC)
      else $error("frame does not end with check word");
  // Second half of every bi-phase bit on track zero must be the inverse of the first
  chk_biphase_half:
    assert property ((s_q.st == bmtsf_pkg::ST_RUN && !s_q.half && s_q.cfg.bip) |=>
                     track_data[0] != $past(track_data[0]))
      else $error("bi-phase half bit not inverted");
  chk_cmd_label:
    assert property ((cap_valid && !cap.fault && cap.kind == 2'h0) |->
                     cap_fmt[19:16] ==
                     (cap.chan_b ? bmtsf_pkg::LAB_CMD_B : bmtsf_pkg::LAB_CMD_A))
      else $error("command word has wrong label");
  chk_data_label:
    assert property ((cap_valid && !cap.fault && cap.kind == 2'h2) |->
                     cap_fmt[19:16] ==
                     (cap.chan_b ? bmtsf_pkg::LAB_CMD_B : bmtsf_pkg::LAB_CMD_A) - 4'h2)
      else $error("data word has wrong label");
  chk_bus_label:
    assert property (cap_valid |-> cap_fmt[22:20] == s_q.cfg.bus[2:0] &&
                     (s_q.cfg.par || cap_fmt[23] == s_q.cfg.bus[3]))
      else $error("bus label bits wrong");
  // Reset acts whatever clk_en does, so this one ignores the enable
  chk_reset_idle:
    assert property (@(posedge ref_clk) disable iff (1'b0)
                     rst |=> s_q.st == bmtsf_pkg::ST_IDLE && track_data == 4'h0)
      else $error("reset did not stop the streams");
endmodule // bmtsf_formatter

// ### sim/bmtsf_tape_model.sv
// Tape recorder side: decodes each track stream and delivers framed 24-bit words.
// Assumes bit_clk is high in the first half of every bit and all tracks share it.
`timescale 1ns/1ns
module bmtsf_tape_model (
  input wire logic ref_clk, // Bench clock
  input wire logic rst, // Synchronous reset
  input wire logic line_nrz, // High when tracks use randomized NRZ-L
  input wire logic bit_clk, // Bit clock from the formatter
  input wire logic [3:0] track_data, // Line coded streams
  input wire logic [3:0] track_active, // Tracks in use
  output logic [3:0] word_valid, // One word completed on a track
  output logic [3:0][23:0] word // Completed word per track
);
  logic [3:0][23:0] sh_q;
  logic [3:0][14:0] hist_q;
  logic [3:0] lock_q;
  logic [3:0][4:0] cnt_q;

  // Only the first half bit is sampled, which suits both line codes
  always @(posedge ref_clk) begin
    logic b;
    logic [23:0] nxt;
    word_valid <= 4'h0;
    for (int t = 0; t < 4; t++) begin
      if (rst || !track_active[t]) begin
        sh_q[t] <= 24'h0;
        hist_q[t] <= 15'h0;
        lock_q[t] <= 1'b0;
        cnt_q[t] <= 5'h0;
      end else if (bit_clk) begin
        b = line_nrz ? track_data[t] ^ hist_q[t][13] ^ hist_q[t][14] : track_data[t];
        nxt = {sh_q[t][22:0], b};
        hist_q[t] <= {hist_q[t][13:0], track_data[t]};
        sh_q[t] <= nxt;
        // Hunt for sync once, then cut every 24 bits
        if (lock_q[t] ? cnt_q[t] == 5'h17 : nxt == bmtsf_pkg::SYNC_WORD) begin
          word_valid[t] <= 1'b1;
          word[t] <= nxt;
          lock_q[t] <= 1'b1;
          cnt_q[t] <= 5'h0;
        end else begin
          cnt_q[t] <= cnt_q[t] + 5'h1;
        end
      end
    end
  end
endmodule // bmtsf_tape_model

// ### sim/bus_monitor_track_spread_formatter_test.sv
// Self-checking bench: runs one frame in four track configurations.
// Assumes the formatter and the tape model; expected words built from seeds.
`timescale 1ns/1ns
module bus_monitor_track_spread_formatter_test;
  logic ref_clk, rst, cap_valid, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  bmtsf_pkg::bmtsf_cap_t cap;
  bmtsf_pkg::bmtsf_time_t frame_time;
  logic awready, wready, bvalid, arready, rvalid, bit_clk, cpar, nrz, watch;
  logic [1:0] bresp, rresp;
  logic [3:0] track_data, track_active, word_valid, cbus;
  logic [3:0][23:0] word;
  int err_total, total_checks, cyc, seed, nw[4], first[4];
  logic [23:0] exp_q[4][$];
  logic [33:0] bq[$], rq[$];

  bmtsf_formatter uut (.ref_clk(ref_clk), .rst(rst), .clk_en(1'b1), .cap_valid(cap_valid),
    .cap(cap), .frame_time(frame_time), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .track_data(track_data), .track_active(track_active), .bit_clk(bit_clk));

  bmtsf_tape_model tape (.ref_clk(ref_clk), .rst(rst), .line_nrz(nrz), .bit_clk(bit_clk),
    .track_data(track_data), .track_active(track_active), .word_valid(word_valid),
    .word(word));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  function automatic logic [23:0] fmt(input logic [3:0] lab, input logic [15:0] info);
    logic [22:0] r;
    r = {cbus[2:0], lab, info};
    return {cpar ? ~^r : cbus[3], r};
  endfunction

  function automatic logic [23:0] capw(input bmtsf_pkg::bmtsf_cap_t c);
    logic [3:0] lab;
    lab = (c.chan_b ? 4'hb : 4'hf) - (c.fault ? 4'h3 : {2'h0, c.kind});
    return fmt(lab, c.raw[16:1]);
  endfunction

  function automatic logic [15:0] crcf(input logic [15:0] c, input logic [15:0] d);
    for (int i = 15; i >= 0; i--) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? bmtsf_pkg::CRC_POLY : 16'h0);
    end
    return c;
  endfunction

  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bq.push_back({r, 32'h0});
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic axr(input logic [7:0] a, input logic [33:0] e);
    rq.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    @(posedge ref_clk);
  endtask

  // All expectations are built before the run starts, so no word can outrun them
  task automatic run_cfg(input logic [1:0] tk, input logic fte, input logic crce,
                         input logic par, input logic bip, input logic [3:0] bus, input int n);
    logic [23:0] seq[$];
    logic [23:0] item;
    logic [15:0] crc[4];
    logic [31:0] ctrl, r;
    logic [63:0] ft;
    bmtsf_pkg::bmtsf_cap_t cq[$];
    bmtsf_pkg::bmtsf_cap_t c;
    int ovf;
    ovf = n > 16;
    cbus = bus;
    cpar = par;
    nrz = !bip;
    ctrl = {21'h0, bus, 1'b1, bip, par, crce, fte, tk};
    ft = {$random(seed), $random(seed)};
    frame_time <= ft[47:0];
    if (fte) seq = {fmt(4'h7, ft[47:32]), fmt(4'h6, ft[31:16]), fmt(4'h5, ft[15:0])};
    for (int i = 0; i < n + ovf; i++) begin
      r = $random(seed);
      c = {r[19:0], (r[21:20] == 2'h3) ? 2'h2 : r[21:20], r[22], r[23]};
      cq.push_back(c);
      if (i < 16) seq.push_back(capw(c));
    end
    if (ovf) seq.push_back(fmt(4'h0, 16'h0));
    if (ovf) seq.push_back(capw(cq[n]));
    for (int t = 0; t <= tk; t++) begin
      nw[t] = 0;
      crc[t] = bmtsf_pkg::CRC_INIT;
      exp_q[t].push_back(bmtsf_pkg::SYNC_WORD);
    end
    for (int s = 1; s < 256; s++) begin
      for (int t = 0; t <= tk; t++) begin
        if (s == 255 && crce) item = fmt(4'h2, crc[t]);
        else item = seq.size() > 0 ? seq.pop_front() : fmt(4'h1, bmtsf_pkg::FILL_INFO);
        crc[t] = crcf(crc[t], item[15:0]);
        exp_q[t].push_back(item);
      end
    end
    for (int t = 0; t <= tk; t++) exp_q[t].push_back(bmtsf_pkg::SYNC_WORD);
    watch = 1'b1;
    axw(8'h00, ctrl, 2'h0);
    for (int i = 0; i < n + ovf; i++) begin
      if (i == n) begin
        cap_valid <= 1'b0;
        repeat (130) @(posedge ref_clk);
      end
      cap <= cq[i];
      cap_valid <= 1'b1;
      @(posedge ref_clk);
    end
    cap_valid <= 1'b0;
    do @(posedge ref_clk);
    while (exp_q[0].size() + exp_q[1].size() + exp_q[2].size() + exp_q[3].size() > 0);
    watch = 1'b0;
    chk(34'(track_active), 34'((5'h1 << (tk + 1)) - 1));
    for (int t = 1; t <= tk; t++) chk(34'(first[t] - first[0]), 34'(t * 48 / (tk + 1)));
    axr(8'h00, {23'h0, ctrl[10:0]});
    axw(8'h00, 32'h0, 2'h0);
    repeat (4) @(posedge ref_clk);
  endtask

  always @(posedge ref_clk) begin
    for (int t = 0; t < 4; t++) begin
      if (word_valid[t] && watch) begin
        if (nw[t] == 0) first[t] = cyc;
        nw[t]++;
        if (exp_q[t].size() == 0) chk(34'(word[t]), 34'h3ffffffff);
        else chk(34'(word[t]), 34'(exp_q[t].pop_front()));
      end
    end
    if (bvalid && bready) chk({bresp, 32'h0}, bq.pop_front());
    if (rvalid && rready) chk({rresp, rdata}, rq.pop_front());
    cyc++;
    if (cyc == 80000) begin
      err_total++;
      conclude();
    end
  end

  initial begin
    seed = 32'hc47d;
    {rst, cap_valid, awvalid, wvalid, bready, arvalid, rready, watch} = 8'h80;
    {cpar, nrz, cbus, awaddr, araddr, wdata} = '0;
    cap = '0;
    frame_time = '0;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    run_cfg(2'h3, 1'b1, 1'b0, 1'b0, 1'b1, 4'h9, 20);
    run_cfg(2'h2, 1'b1, 1'b1, 1'b1, 1'b0, 4'h3, 5);
    run_cfg(2'h1, 1'b0, 1'b1, 1'b0, 1'b1, 4'hf, 5);
    run_cfg(2'h0, 1'b0, 1'b0, 1'b1, 1'b0, 4'h0, 5);
    axw(8'h04, 32'hffffffff, bmtsf_pkg::RESP_OK);
    axw(8'h20, 32'h1, bmtsf_pkg::RESP_SLVERR);
    axr(8'h20, {bmtsf_pkg::RESP_SLVERR, 32'h0});
    conclude();
  end
endmodule // bus_monitor_track_spread_formatter_test
